// File: plsv_link_sup.sv
// link supervision core: loss monitor, downshift, mirror, test modes, straps
`timescale 1ns/1ps
module plsv_link_sup #(
  parameter int LL_WIN_100M_CYC = plsv_pkg::LL_100M_CYC,
  parameter int LL_WIN_1G_CYC = plsv_pkg::LL_1G_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [1:0] strap_spd_lvl_i,
  input wire logic [1:0] strap_mirror_lvl_i,
  input wire logic [1:0] strap_fdetect_lvl_i,
  input wire logic [1:0] strap_fdown_lvl_i,
  input wire logic [7:0] rx_sample_i,
  input wire logic [7:0] ed_hi_thr_i,
  input wire logic [7:0] ed_lo_thr_i,
  input wire logic [7:0] ed_listen_i,
  input wire logic descr_sync_i,
  input wire logic rx_err_i,
  input wire logic mlt3_err_i,
  input wire logic mse_bad_i,
  input wire logic attempt_done_i,
  input wire logic attempt_ok_i,
  input wire logic energy_cd_i,
  input wire logic [7:0] eq_coef_i,
  output logic link_up_o,
  output logic link_loss_o,
  output logic [2:0] speed_o,
  output logic [3:0] fle_mode_o,
  output logic [7:0] pair_map_o,
  output logic [7:0] cable_len_o,
  output logic [2:0] test_mode_o,
  output logic clk_out_o,
  output logic [1:0] tx_sym_o,
  output logic int_b_o
);
  plsv_pkg::plsv_core_st_t st_ff;
  plsv_pkg::plsv_core_st_t nxt_st;
  plsv_ed_if edi ();
  logic soft_rst;
  logic load;
  logic rd_stat;
  logic [4:0] crit;
  logic [4:0] ev;
  logic bad;
  logic [15:0] win;
  logic [2:0] ds_lim;
  logic [2:0] fail_n;
  logic tm_act;
  logic [8:0] len_sum;

  assign edi.sample = rx_sample_i;
  assign edi.hi_thr = ed_hi_thr_i;
  assign edi.lo_thr = ed_lo_thr_i;
  assign edi.listen = ed_listen_i;

  plsv_energy_det u_ed (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ed(edi.det)
  );

  assign crit = st_ff.config_three[plsv_pkg::FDOWN_CRIT_LSB +: 5];
  assign ds_lim = st_ff.config_four[plsv_pkg::DS_LIM_LSB +: 3];
  assign fail_n = st_ff.fail_cnt + 3'h1;
  assign tm_act = (st_ff.config_one[plsv_pkg::TM_LSB +: 3] != 3'h0)
    && (st_ff.config_one[plsv_pkg::TM_LSB +: 3] <= plsv_pkg::TM_LAST);
  assign len_sum = {1'b0, st_ff.cable_len} + {1'b0, eq_coef_i};
  assign soft_rst = reg_wr_i && reg_addr_i == plsv_pkg::CONFIG_FOUR_OFS
    && reg_wdata_i[plsv_pkg::SOFT_RST_BIT];
  assign load = !st_ff.strap_done || soft_rst;
  assign rd_stat = reg_rd_i && reg_addr_i == plsv_pkg::INT_STAT_OFS;

  always_comb begin
    if (st_ff.config_three[plsv_pkg::FDOWN_EN_BIT]) begin
      win = plsv_pkg::LL_FAST_CYC;
      bad = (crit[plsv_pkg::CRIT_SYNC] && !descr_sync_i)
        || (crit[plsv_pkg::CRIT_RXERR] && rx_err_i)
        || (crit[plsv_pkg::CRIT_MLT3] && mlt3_err_i)
        || (crit[plsv_pkg::CRIT_MSE] && mse_bad_i)
        || (crit[plsv_pkg::CRIT_ENERGY] && !edi.present);
    end else begin
      win = (st_ff.spd == plsv_pkg::SPD_1G) ? 16'(LL_WIN_1G_CYC) : 16'(LL_WIN_100M_CYC);
      bad = !descr_sync_i;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    ev = 5'h00;
    nxt_st.link_loss = 1'b0;
    nxt_st.rvalid = reg_rd_i;
    // capture straps once, at the first edge after hard reset release
    if (!st_ff.strap_done) begin
      nxt_st.strap_done = 1'b1;
      nxt_st.s_spd = strap_spd_lvl_i;
      nxt_st.s_mir = strap_mirror_lvl_i;
      nxt_st.s_fdet = strap_fdetect_lvl_i;
      nxt_st.s_fdown = strap_fdown_lvl_i;
    end
    if (reg_wr_i && reg_addr_i == plsv_pkg::CONFIG_ONE_OFS) begin
      nxt_st.config_one = reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == plsv_pkg::INT_CTRL_OFS) begin
      nxt_st.interrupt_control = reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == plsv_pkg::CONFIG_THREE_OFS) begin
      nxt_st.config_three = reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == plsv_pkg::CONFIG_FOUR_OFS) begin
      nxt_st.config_four = reg_wdata_i & ~(16'h0001 << plsv_pkg::SOFT_RST_BIT);
    end
    if (load) begin
      // strap-derived defaults come from the stored samples, never the pins
      nxt_st.config_one = plsv_pkg::CONFIG_ONE_RST;
      nxt_st.interrupt_control = plsv_pkg::INT_CTRL_RST;
      nxt_st.config_three = plsv_pkg::CONFIG_THREE_RST;
      nxt_st.config_three[plsv_pkg::FDETECT_BIT] = (nxt_st.s_fdet == 2'h1);
      nxt_st.config_three[plsv_pkg::FDOWN_EN_BIT] = nxt_st.s_fdown[0];
      nxt_st.config_three[plsv_pkg::FDOWN_CRIT_LSB + plsv_pkg::CRIT_ENERGY] = nxt_st.s_fdown[0];
      nxt_st.config_four = plsv_pkg::CONFIG_FOUR_RST;
      nxt_st.config_four[plsv_pkg::DS_EN_BIT] = nxt_st.s_spd[1];
      nxt_st.config_four[plsv_pkg::MIRROR_BIT] = nxt_st.s_mir[0];
    end

    if (st_ff.rdata != 16'h0000 && !reg_rd_i) begin
      nxt_st.rdata = 16'h0000;
    end
    if (reg_rd_i && reg_addr_i == plsv_pkg::CONFIG_ONE_OFS) begin
      nxt_st.rdata = st_ff.config_one;
    end else if (reg_rd_i && reg_addr_i == plsv_pkg::INT_CTRL_OFS) begin
      nxt_st.rdata = st_ff.interrupt_control;
    end else if (rd_stat) begin
      nxt_st.rdata = {11'h000, st_ff.interrupt_status};
    end else if (reg_rd_i && reg_addr_i == plsv_pkg::CONFIG_THREE_OFS) begin
      nxt_st.rdata = st_ff.config_three;
    end else if (reg_rd_i && reg_addr_i == plsv_pkg::CONFIG_FOUR_OFS) begin
      nxt_st.rdata = st_ff.config_four;
    end else if (reg_rd_i) begin
      nxt_st.rdata = 16'h0000;
    end

    // link-loss monitor over a window of consecutive bad cycles
    if (st_ff.link_up && bad) begin
      if (st_ff.bad_cnt >= win - 16'h0001) begin
        nxt_st.link_up = 1'b0;
        nxt_st.link_loss = 1'b1;
        nxt_st.bad_cnt = 16'h0000;
        ev[plsv_pkg::IS_LINK] = 1'b1;
        ev[plsv_pkg::IS_LOSS] = 1'b1;
      end else begin
        nxt_st.bad_cnt = st_ff.bad_cnt + 16'h0001;
      end
    end else begin
      nxt_st.bad_cnt = 16'h0000;
    end

    // link attempts and speed downshift
    if (!st_ff.config_four[plsv_pkg::DS_EN_BIT]) begin
      nxt_st.fail_cnt = 3'h0;
      nxt_st.spd = plsv_pkg::SPD_1G;
    end
    if (attempt_done_i && !st_ff.link_up) begin
      if (attempt_ok_i) begin
        nxt_st.link_up = 1'b1;
        nxt_st.fail_cnt = 3'h0;
        ev[plsv_pkg::IS_LINK] = 1'b1;
      end else if (st_ff.config_four[plsv_pkg::DS_EN_BIT]) begin
        nxt_st.fail_cnt = fail_n;
        case (st_ff.spd)
          plsv_pkg::SPD_1G: begin
            if (fail_n >= ds_lim || (st_ff.config_four[plsv_pkg::DS_ENH_BIT] && !energy_cd_i)) begin
              nxt_st.spd = plsv_pkg::SPD_100;
              nxt_st.fail_cnt = 3'h0;
              ev[plsv_pkg::IS_SPEED] = 1'b1;
              ev[plsv_pkg::IS_DSHIFT] = 1'b1;
            end
          end
          plsv_pkg::SPD_100: begin
            if (fail_n >= ds_lim) begin
              nxt_st.spd = plsv_pkg::SPD_10;
              nxt_st.fail_cnt = 3'h0;
              ev[plsv_pkg::IS_SPEED] = 1'b1;
              ev[plsv_pkg::IS_DSHIFT] = 1'b1;
            end
          end
          default: begin
            nxt_st.fail_cnt = 3'h0;
          end
        endcase
      end
    end
    ev[plsv_pkg::IS_ENERGY] = edi.change;

    // receive-side passive length estimate, smoothed, only with link up
    if (st_ff.link_up) begin
      nxt_st.cable_len = len_sum[8:1];
    end

    // mirror swaps A/D, B/C; at 10/100 only the A and B entries matter
    nxt_st.pair_map = st_ff.config_four[plsv_pkg::MIRROR_BIT] ? plsv_pkg::MAP_MIRROR
      : plsv_pkg::MAP_STRAIGHT;

    // transmit test modes: half-rate clock with pattern stepped on its rise
    if (tm_act) begin
      nxt_st.clk_out = !st_ff.clk_out;
      if (!st_ff.clk_out) begin
        nxt_st.lfsr = {st_ff.lfsr[9:0], st_ff.lfsr[10] ^ st_ff.lfsr[8]};
        case (st_ff.config_one[plsv_pkg::TM_LSB +: 3])
          3'h1: nxt_st.sym = st_ff.sym ^ 2'h2;
          3'h4: nxt_st.sym = st_ff.lfsr[1:0];
          default: nxt_st.sym = {1'b0, !st_ff.sym[0]};
        endcase
      end
    end else begin
      nxt_st.clk_out = 1'b0;
      nxt_st.sym = 2'h0;
    end

    // sticky status: read clears, a new event in the same cycle survives
    if (soft_rst) begin
      nxt_st.interrupt_status = 5'h00;
    end else if (rd_stat) begin
      nxt_st.interrupt_status = ev;
    end else begin
      nxt_st.interrupt_status = st_ff.interrupt_status | ev;
    end
    nxt_st.int_b = !(|(nxt_st.interrupt_status & nxt_st.interrupt_control[4:0]));
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= plsv_pkg::CORE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o = st_ff.rdata;
  assign reg_rvalid_o = st_ff.rvalid;
  assign link_up_o = st_ff.link_up;
  assign link_loss_o = st_ff.link_loss;
  assign speed_o = st_ff.spd;
  assign fle_mode_o = st_ff.config_three[plsv_pkg::FLE_MODE_LSB +: 4];
  assign pair_map_o = st_ff.pair_map;
  assign cable_len_o = st_ff.cable_len;
  assign test_mode_o = tm_act ? st_ff.config_one[plsv_pkg::TM_LSB +: 3] : 3'h0;
  assign clk_out_o = st_ff.clk_out;
  assign tx_sym_o = st_ff.sym;
  assign int_b_o = st_ff.int_b;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_loss_window: assert property (st_ff.link_loss |-> $past(st_ff.bad_cnt) == $past(win) - 16'h0001)
    else $error("link loss declared at wrong window count");
  a_fast_crit: assert property (st_ff.link_up && st_ff.config_three[plsv_pkg::FDOWN_EN_BIT] && crit == 5'h00
    |=> !st_ff.link_loss) else $error("loss raised with no criterion enabled");
  a_ds_count: assert property (attempt_done_i && !attempt_ok_i && !st_ff.link_up
    && st_ff.config_four[plsv_pkg::DS_EN_BIT] && st_ff.spd == plsv_pkg::SPD_1G && fail_n >= ds_lim
    |=> st_ff.spd == plsv_pkg::SPD_100) else $error("no downshift after failure limit");
  a_ds_enh: assert property (attempt_done_i && !attempt_ok_i && !st_ff.link_up && !energy_cd_i
    && st_ff.config_four[plsv_pkg::DS_EN_BIT] && st_ff.config_four[plsv_pkg::DS_ENH_BIT]
    && st_ff.spd == plsv_pkg::SPD_1G |=> st_ff.spd == plsv_pkg::SPD_100)
    else $error("enhanced downshift missed");
  a_ds_ten: assert property (attempt_done_i && !attempt_ok_i && !st_ff.link_up
    && st_ff.config_four[plsv_pkg::DS_EN_BIT] && st_ff.spd == plsv_pkg::SPD_100 && fail_n >= ds_lim
    |=> st_ff.spd == plsv_pkg::SPD_10) else $error("no fallback to 10M");
  a_cnt_clear: assert property ((attempt_done_i && attempt_ok_i && !st_ff.link_up)
    || !st_ff.config_four[plsv_pkg::DS_EN_BIT] |=> st_ff.fail_cnt == 3'h0)
    else $error("failure count not cleared");
  a_mirror_map: assert property (st_ff.config_four[plsv_pkg::MIRROR_BIT]
    && $past(st_ff.config_four[plsv_pkg::MIRROR_BIT]) |-> pair_map_o == plsv_pkg::MAP_MIRROR)
    else $error("mirror map wrong");
  a_int_hold: assert property (!int_b_o && !rd_stat && !soft_rst
    && !(reg_wr_i && reg_addr_i == plsv_pkg::INT_CTRL_OFS) |=> !int_b_o)
    else $error("interrupt dropped before status read");
  a_int_link: assert property ($rose(st_ff.link_up) && st_ff.interrupt_control[plsv_pkg::IS_LINK]
    && !$past(soft_rst) |-> !int_b_o) else $error("link change gave no interrupt");
  a_tm_clock: assert property (tm_act && $past(tm_act) |-> clk_out_o != $past(clk_out_o))
    else $error("test clock not toggling");
  a_strap_reload: assert property (st_ff.strap_done && soft_rst
    |=> st_ff.config_four[plsv_pkg::DS_EN_BIT] == st_ff.s_spd[1]) else $error("strap not reloaded");
  a_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_loss_pulse: assert property (link_loss_o |=> !link_loss_o)
    else $error("link loss pulse too long");
  a_len_hold: assert property (!st_ff.link_up |=> $stable(cable_len_o))
    else $error("cable length moved without link");
  a_soft_clear: assert property (soft_rst |=> int_b_o && st_ff.interrupt_status == 5'h00)
    else $error("soft reset left status pending");
  a_tm_idle: assert property (!tm_act |=> !clk_out_o && tx_sym_o == 2'h0)
    else $error("test outputs active outside test mode");

  c_downshift: cover property (st_ff.spd == plsv_pkg::SPD_1G ##1 st_ff.spd == plsv_pkg::SPD_100);
  c_ten: cover property (st_ff.spd == plsv_pkg::SPD_10);
  c_loss: cover property (st_ff.link_loss && st_ff.config_three[plsv_pkg::FDOWN_EN_BIT]);
  c_test: cover property (tm_act && st_ff.config_one[plsv_pkg::TM_LSB +: 3] == plsv_pkg::TM_LAST);
  c_int: cover property ($fell(int_b_o));
endmodule : plsv_link_sup

// File: plsv_pkg.sv
// constants, types and state layouts for the link supervision block
package plsv_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int LL_100M_NS = 1000000;
  localparam int LL_1G_NS = 500000;
  localparam int LL_FAST_NS = 10000;
  localparam int LL_100M_CYC = LL_100M_NS / CLK_PERIOD_NS;
  localparam int LL_1G_CYC = LL_1G_NS / CLK_PERIOD_NS;
  localparam logic [15:0] LL_FAST_CYC = 16'(LL_FAST_NS / CLK_PERIOD_NS);

  localparam logic [7:0] CONFIG_ONE_OFS = 8'h09;
  localparam logic [7:0] INT_CTRL_OFS = 8'h12;
  localparam logic [7:0] INT_STAT_OFS = 8'h13;
  localparam logic [7:0] CONFIG_THREE_OFS = 8'h1E;
  localparam logic [7:0] CONFIG_FOUR_OFS = 8'h31;

  localparam int TM_LSB = 13;
  localparam logic [2:0] TM_LAST = 3'h4;
  localparam int FLE_MODE_LSB = 0;
  localparam int FDETECT_BIT = 0;
  localparam int FDOWN_EN_BIT = 4;
  localparam int FDOWN_CRIT_LSB = 5;
  localparam int CRIT_SYNC = 0;
  localparam int CRIT_RXERR = 1;
  localparam int CRIT_MLT3 = 2;
  localparam int CRIT_MSE = 3;
  localparam int CRIT_ENERGY = 4;
  localparam int MIRROR_BIT = 0;
  localparam int DS_EN_BIT = 1;
  localparam int DS_ENH_BIT = 2;
  localparam int DS_LIM_LSB = 3;
  localparam int SOFT_RST_BIT = 15;

  localparam int IS_LINK = 0;
  localparam int IS_SPEED = 1;
  localparam int IS_ENERGY = 2;
  localparam int IS_LOSS = 3;
  localparam int IS_DSHIFT = 4;

  localparam logic [15:0] CONFIG_ONE_RST = 16'h0000;
  localparam logic [15:0] INT_CTRL_RST = 16'h0000;
  localparam logic [15:0] CONFIG_THREE_RST = 16'h0000;
  localparam logic [15:0] CONFIG_FOUR_RST = 16'h0020;
  localparam logic [7:0] MAP_STRAIGHT = 8'h1B;
  localparam logic [7:0] MAP_MIRROR = 8'hE4;
  localparam logic [10:0] LFSR_SEED = 11'h7FF;

  typedef enum logic [2:0] {
    SPD_1G = 3'b001,
    SPD_100 = 3'b010,
    SPD_10 = 3'b100
  } plsv_spd_t;

  typedef struct packed {
    logic [11:0] acc;
    logic [7:0] lcnt;
    logic present;
    logic change;
  } plsv_ed_st_t;

  typedef struct packed {
    logic strap_done;
    logic [1:0] s_spd;
    logic [1:0] s_mir;
    logic [1:0] s_fdet;
    logic [1:0] s_fdown;
    logic [15:0] config_one;
    logic [15:0] interrupt_control;
    logic [15:0] config_three;
    logic [15:0] config_four;
    logic [4:0] interrupt_status;
    logic [15:0] rdata;
    logic rvalid;
    plsv_spd_t spd;
    logic link_up;
    logic link_loss;
    logic [15:0] bad_cnt;
    logic [2:0] fail_cnt;
    logic [7:0] pair_map;
    logic [7:0] cable_len;
    logic clk_out;
    logic [10:0] lfsr;
    logic [1:0] sym;
    logic int_b;
  } plsv_core_st_t;

  localparam plsv_core_st_t CORE_RST = '{spd: SPD_1G, int_b: 1'b1, lfsr: LFSR_SEED,
    config_four: CONFIG_FOUR_RST, pair_map: MAP_STRAIGHT, default: '0};
endpackage : plsv_pkg

// File: plsv_ed_if.sv
// carrier between the supervision core and its energy detector
`timescale 1ns/1ps
interface plsv_ed_if;
  logic [7:0] sample;
  logic [7:0] hi_thr;
  logic [7:0] lo_thr;
  logic [7:0] listen;
  logic present;
  logic change;
  modport det (input sample, input hi_thr, input lo_thr, input listen,
    output present, output change);
  modport ctl (output sample, output hi_thr, output lo_thr, output listen,
    input present, input change);
endinterface : plsv_ed_if

// File: plsv_energy_det.sv
// filtered energy detector with hysteresis and listening period
`timescale 1ns/1ps
module plsv_energy_det (
  input wire logic clk_i,
  input wire logic rst_b_i,
  plsv_ed_if.det ed
);
  plsv_pkg::plsv_ed_st_t st_ff;
  plsv_pkg::plsv_ed_st_t nxt_st;
  logic [7:0] level;

  assign level = st_ff.acc[11:4];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.change = 1'b0;
    // first-order iir, settles at sixteen times the sample
    nxt_st.acc = st_ff.acc + {4'h0, ed.sample} - {4'h0, st_ff.acc[11:4]};
    if (st_ff.lcnt >= ed.listen) begin
      nxt_st.lcnt = 8'h00;
      if (!st_ff.present && level >= ed.hi_thr) begin
        nxt_st.present = 1'b1;
        nxt_st.change = 1'b1;
      end else if (st_ff.present && level < ed.lo_thr) begin
        nxt_st.present = 1'b0;
        nxt_st.change = 1'b1;
      end
    end else begin
      nxt_st.lcnt = st_ff.lcnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ed.present = st_ff.present;
  assign ed.change = st_ff.change;

  a_ed_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (st_ff.lcnt < ed.listen) |=> $stable(st_ff.present))
    else $error("energy indication moved inside listening period");
endmodule : plsv_energy_det

// File: plsv_link_partner.sv
// link partner model driving the receive side of the supervision core
`timescale 1ns/1ps
module plsv_link_partner (
  input wire logic clk_i,
  output logic [7:0] rx_sample_o,
  output logic descr_sync_o,
  output logic rx_err_o,
  output logic mlt3_err_o,
  output logic mse_bad_o,
  output logic attempt_done_o,
  output logic attempt_ok_o,
  output logic energy_cd_o,
  output logic [7:0] eq_coef_o
);
  logic energy_on = 1'b0;
  logic dith = 1'b0;
  logic [3:0] bad = 4'h0;
  initial begin
    attempt_done_o = 1'b0;
    attempt_ok_o = 1'b0;
    energy_cd_o = 1'b1;
    eq_coef_o = 8'h00;
  end
  always @(posedge clk_i) begin
    #1;
    dith = ~dith;
  end
  // no energy on the line when silent
  assign rx_sample_o = energy_on ? {7'h60, dith} : 8'h00;
  assign descr_sync_o = ~bad[0];
  assign rx_err_o = bad[1];
  assign mlt3_err_o = bad[2];
  assign mse_bad_o = bad[3];
  task automatic set_line(input logic on, input logic [7:0] eq);
    energy_on = on;
    eq_coef_o = eq;
  endtask : set_line
  task automatic attempt(input logic ok, input logic cd);
    @(posedge clk_i);
    #1;
    attempt_done_o = 1'b1;
    attempt_ok_o = ok;
    energy_cd_o = cd;
    @(posedge clk_i);
    #1;
    attempt_done_o = 1'b0;
    // released result shows the inverse
    attempt_ok_o = ~ok;
  endtask : attempt
  task automatic impair(input int k, input logic b);
    @(posedge clk_i);
    #1;
    bad[k] = b;
  endtask : impair
endmodule : plsv_link_partner

// File: test_phy_link_supervision.sv
// self-checking bench for the link supervision core
`timescale 1ns/1ps
module test_phy_link_supervision;
  localparam int WIN_100 = 40;
  localparam int WIN_1G = 20;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic rvalid;
  logic [1:0] s_spd = 2'h2;
  logic [1:0] s_mir = 2'h1;
  logic [1:0] s_fdet = 2'h1;
  logic [1:0] s_fdown = 2'h1;
  logic [7:0] rx_sample, eq_coef, cable_len, pair_map;
  logic sync, rx_err, mlt3, mean_square_error_metric, a_done, a_ok, e_cd;
  logic link_up, link_loss, clk_out, int_b, prev;
  logic [2:0] speed, test_mode;
  logic [3:0] fle_mode;
  logic [1:0] tx_sym;
  logic [15:0] rd_val;
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 21;
  int m_spd = 1;
  int m_fail = 0;
  int m_enh = 0;
  int n;

  always #10 clk_i = ~clk_i;

  plsv_link_sup #(.LL_WIN_100M_CYC(WIN_100), .LL_WIN_1G_CYC(WIN_1G)) u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .strap_spd_lvl_i(s_spd), .strap_mirror_lvl_i(s_mir), .strap_fdetect_lvl_i(s_fdet),
    .strap_fdown_lvl_i(s_fdown), .rx_sample_i(rx_sample), .ed_hi_thr_i(8'h64),
    .ed_lo_thr_i(8'h32), .ed_listen_i(8'h03), .descr_sync_i(sync), .rx_err_i(rx_err),
    .mlt3_err_i(mlt3), .mse_bad_i(mean_square_error_metric), .attempt_done_i(a_done), .attempt_ok_i(a_ok),
    .energy_cd_i(e_cd), .eq_coef_i(eq_coef), .link_up_o(link_up), .link_loss_o(link_loss),
    .speed_o(speed), .fle_mode_o(fle_mode), .pair_map_o(pair_map), .cable_len_o(cable_len),
    .test_mode_o(test_mode), .clk_out_o(clk_out), .tx_sym_o(tx_sym), .int_b_o(int_b));

  plsv_link_partner u_lp (.clk_i(clk_i), .rx_sample_o(rx_sample), .descr_sync_o(sync),
    .rx_err_o(rx_err), .mlt3_err_o(mlt3), .mse_bad_o(mean_square_error_metric), .attempt_done_o(a_done),
    .attempt_ok_o(a_ok), .energy_cd_o(e_cd), .eq_coef_o(eq_coef));

  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t pin got %h exp %h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk_i);
    #1;
    wr = 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    #1;
    rd = 1'b1;
    addr = a;
    @(posedge clk_i);
    #1;
    rd = 1'b0;
    chk_pin({7'h0, rvalid}, 8'h01);
    d = rdata;
  endtask : reg_read

  task automatic fail_try(input logic cd);
    u_lp.attempt(1'b0, cd);
    m_fail++;
    if (m_fail >= 4 || (m_enh != 0 && !cd && m_spd == 1)) begin
      m_spd = (m_spd == 1) ? 2 : 4;
      m_fail = 0;
    end
    chk_pin({5'h0, speed}, 8'(m_spd));
  endtask : fail_try

  task automatic link_on;
    int d;
    u_lp.set_line(1'b1, 8'h40 | (8'($random(seed)) & 8'h1F));
    u_lp.attempt(1'b1, 1'b1);
    m_fail = 0;
    chk_pin({7'h0, link_up}, 8'h01);
    repeat (20) @(posedge clk_i);
    #1;
    d = int'(cable_len) - int'(eq_coef);
    chk_pin({7'h0, d <= 5 && d >= -5}, 8'h01);
  endtask : link_on

  task automatic wait_loss(output int cnt);
    cnt = 0;
    while (link_loss !== 1'b1 && cnt < 1000) begin
      @(posedge clk_i);
      #1;
      cnt++;
    end
    if (cnt >= 1000) begin
      n_errors++;
      summarize();
    end else begin
      chk_pin({7'h0, link_up}, 8'h00);
    end
  endtask : wait_loss

  initial begin
    repeat (20) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    u_lp.set_line(1'b1, 8'h40);
    repeat (300) @(posedge clk_i);
    reg_read(plsv_pkg::CONFIG_ONE_OFS, rd_val);
    chk_reg(rd_val, 16'h0000);
    reg_read(plsv_pkg::CONFIG_THREE_OFS, rd_val);
    chk_reg(rd_val, 16'h0211);
    reg_read(plsv_pkg::CONFIG_FOUR_OFS, rd_val);
    chk_reg(rd_val, 16'h0023);
    chk_pin({4'h0, fle_mode}, 8'h01);
    chk_pin(pair_map, 8'hE4);
    reg_read(8'h05, rd_val);
    chk_reg(rd_val, 16'h0000);
    reg_read(plsv_pkg::INT_STAT_OFS, rd_val);
    chk_reg(rd_val, 16'h0004);
    reg_write(plsv_pkg::INT_CTRL_OFS, 16'h001F);
    repeat (8) fail_try(1'b1);
    chk_pin(pair_map, 8'hE4);
    chk_pin({7'h0, int_b}, 8'h00);
    reg_read(plsv_pkg::INT_STAT_OFS, rd_val);
    chk_reg(rd_val, 16'h0012);
    chk_pin({7'h0, int_b}, 8'h01);
    reg_write(plsv_pkg::CONFIG_FOUR_OFS, 16'h0021);
    m_spd = 1;
    // speed is forced back one edge after the enable drops
    @(posedge clk_i);
    #1;
    chk_pin({5'h0, speed}, 8'h01);
    reg_write(plsv_pkg::CONFIG_FOUR_OFS, 16'h0027);
    m_enh = 1;
    fail_try(1'b0);
    // default loss monitor: strapped fast energy criterion off
    reg_write(plsv_pkg::CONFIG_THREE_OFS, 16'h0001);
    link_on();
    u_lp.impair(0, 1'b1);
    wait_loss(n);
    chk_reg(16'(n), 16'(WIN_100));
    u_lp.impair(0, 1'b0);
    reg_write(plsv_pkg::CONFIG_FOUR_OFS, 16'h0021);
    reg_write(plsv_pkg::CONFIG_FOUR_OFS, 16'h0023);
    m_enh = 0;
    m_spd = 1;
    reg_read(plsv_pkg::INT_STAT_OFS, rd_val);
    repeat (3) fail_try(1'b1);
    link_on();
    u_lp.impair(0, 1'b1);
    wait_loss(n);
    chk_reg(16'(n), 16'(WIN_1G));
    u_lp.impair(0, 1'b0);
    chk_pin({7'h0, int_b}, 8'h00);
    reg_read(plsv_pkg::INT_STAT_OFS, rd_val);
    chk_reg(rd_val, 16'h0009);
    repeat (3) fail_try(1'b1);
    for (int k = 0; k < 4; k++) begin
      reg_write(plsv_pkg::CONFIG_THREE_OFS, 16'h0010 | (16'h0020 << k));
      link_on();
      u_lp.impair(k, 1'b1);
      wait_loss(n);
      chk_reg(16'(n), plsv_pkg::LL_FAST_CYC);
      u_lp.impair(k, 1'b0);
    end
    for (int tm = 0; tm < 8; tm++) begin
      reg_write(plsv_pkg::CONFIG_ONE_OFS, 16'(tm) << plsv_pkg::TM_LSB);
      chk_pin({5'h0, test_mode}, (tm >= 1 && tm <= 4) ? 8'(tm) : 8'h00);
      @(posedge clk_i);
      #1;
      prev = clk_out;
      @(posedge clk_i);
      #1;
      chk_pin({7'h0, clk_out ^ prev}, (tm >= 1 && tm <= 4) ? 8'h01 : 8'h00);
      if (tm == 0 || tm > 4) begin
        chk_pin({6'h0, tx_sym}, 8'h00);
      end else if (tm == 1) begin
        chk_pin({6'h0, tx_sym}, 8'h02);
      end
    end
    reg_write(plsv_pkg::CONFIG_FOUR_OFS, 16'h0022);
    // pair map follows the register one edge later
    @(posedge clk_i);
    #1;
    chk_pin(pair_map, 8'h1B);
    s_spd = 2'h0;
    s_mir = 2'h0;
    s_fdet = 2'h0;
    s_fdown = 2'h0;
    reg_write(plsv_pkg::CONFIG_FOUR_OFS, 16'h8000);
    reg_read(plsv_pkg::CONFIG_FOUR_OFS, rd_val);
    chk_reg(rd_val, 16'h0023);
    reg_read(plsv_pkg::CONFIG_THREE_OFS, rd_val);
    chk_reg(rd_val, 16'h0211);
    chk_pin({4'h0, fle_mode}, 8'h01);
    chk_pin(pair_map, 8'hE4);
    summarize();
  end
endmodule : test_phy_link_supervision
